// ---- include/usb_dma_regs_pkg.sv ----
// Package with register map, field layout and reset values of the DMA control block
package usb_dma_regs_pkg;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CORE_EOI = 8'h00;
  localparam logic [7:0] OFS_TX_CTRL = 8'h04;
  localparam logic [7:0] OFS_TX_TEARDOWN = 8'h08;
  localparam logic [7:0] OFS_DMA_EOI = 8'h0C;
  localparam logic [7:0] OFS_TX_MASKED = 8'h10;
  localparam logic [7:0] OFS_TX_RAW = 8'h14;
  localparam logic [7:0] OFS_TX_IEN_SET = 8'h18;
  localparam logic [7:0] OFS_TX_IEN_CLR = 8'h1C;
  localparam logic [7:0] OFS_RX_CTRL = 8'h20;
  localparam logic [7:0] OFS_RX_MASKED = 8'h24;
  localparam logic [7:0] OFS_RX_RAW = 8'h28;
  localparam logic [7:0] OFS_RX_IEN_SET = 8'h2C;
  localparam logic [7:0] OFS_RX_IEN_CLR = 8'h30;
  localparam logic [7:0] OFS_RX0_TALLY = 8'h34;
  localparam logic [7:0] OFS_STATUS_CLR = 8'h38;
  // ****************************************
  // Field layout and widths
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int NCH = 4;
  localparam int VEC_W = 8;
  localparam int TALLY_W = 16;
  localparam int RUN_BIT = 0;
  localparam int READY_BIT = 31;
  localparam int CHAN_W = 2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [VEC_W-1:0] EOI_ACK_VEC = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [NCH-1:0] NCH_ZERO = 4'h0;
  localparam logic [TALLY_W-1:0] TALLY_ZERO = 16'h0000;
  localparam logic [TALLY_W-1:0] TALLY_ONE = 16'h0001;
endpackage

// ---- hdl/usb_dma_flag_bank.sv ----
// Sticky completion flags with set-over-clear and software enable set/clear
module usb_dma_flag_bank
  import usb_dma_regs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [NCH-1:0] i_event,
  input wire logic [NCH-1:0] i_flag_clr,
  input wire logic [NCH-1:0] i_en_set,
  input wire logic [NCH-1:0] i_en_clr,
  output logic [NCH-1:0] o_raw,
  output logic [NCH-1:0] o_enable,
  output logic [NCH-1:0] o_masked
);
  logic [NCH-1:0] raw_d;
  logic [NCH-1:0] en_d;
  // Event wins over a clear in the same cycle
  assign raw_d = (o_raw & ~i_flag_clr) | i_event;
  // Set wins over clear on simultaneous writes
  assign en_d = (o_enable & ~i_en_clr) | i_en_set;
  assign o_masked = o_raw & o_enable;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_raw <= NCH_ZERO;
      o_enable <= NCH_ZERO;
    end else begin
      o_raw <= raw_d;
      o_enable <= en_d;
    end
  end
endmodule

// ---- hdl/usb_dma_sync2.sv ----
// Two flip-flop synchroniser for a bus of level inputs
module usb_dma_sync2 #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// ---- hdl/usb_dma_control_irq_regs.sv ----
// DMA control, teardown, completion status and interrupt register block
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
module usb_dma_control_irq_regs
  import usb_dma_regs_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_RESET_N,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [NCH-1:0] I_TX_DONE,
  input wire logic [NCH-1:0] I_RX_DONE,
  input wire logic I_RX0_BUF_TAKEN,
  input wire logic I_TEARDOWN_BUSY,
  output logic O_TX_DMA_RUN,
  output logic O_RX_DMA_RUN,
  output logic O_TEARDOWN_REQ,
  output logic [CHAN_W-1:0] O_TEARDOWN_CHAN,
  output logic O_CORE_EOI,
  output logic O_DMA_EOI,
  output logic O_DMA_IRQ
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int SYNC_W = 2 * NCH + 2;
  logic [SYNC_W-1:0] sync_out;
  logic [NCH-1:0] tx_done_s;
  logic [NCH-1:0] rx_done_s;
  logic rx0_taken_s;
  logic td_busy_s;
  usb_dma_sync2 #(.W(SYNC_W)) u_sync (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RESET_N),
    .i_async({I_TEARDOWN_BUSY, I_RX0_BUF_TAKEN, I_RX_DONE, I_TX_DONE}),
    .o_sync(sync_out)
  );
  assign tx_done_s = sync_out[NCH-1:0];
  assign rx_done_s = sync_out[2*NCH-1:NCH];
  assign rx0_taken_s = sync_out[2*NCH];
  assign td_busy_s = sync_out[2*NCH+1];

  // Pulse detection on synchronised levels
  logic [SYNC_W-1:0] sync_prev_q;
  logic [NCH-1:0] tx_evt;
  logic [NCH-1:0] rx_evt;
  logic rx0_take_evt;
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      sync_prev_q <= '0;
    end else begin
      sync_prev_q <= sync_out;
    end
  end
  assign tx_evt = tx_done_s & ~sync_prev_q[NCH-1:0];
  assign rx_evt = rx_done_s & ~sync_prev_q[2*NCH-1:NCH];
  assign rx0_take_evt = rx0_taken_s & ~sync_prev_q[2*NCH];

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  logic aw_held_q, w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_take, w_take, wr_fire, wr_hit;
  assign aw_take = I_AWVALID && O_AWREADY;
  assign w_take = I_WVALID && O_WREADY;
  assign wr_fire = aw_held_q && w_held_q && !O_BVALID;
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= WORD_ZERO;
      wstrb_q <= 4'h0;
      O_AWREADY <= 1'b0;
      O_WREADY <= 1'b0;
      O_BVALID <= 1'b0;
      O_BRESP <= RESP_OKAY;
    end else begin
      O_AWREADY <= !aw_held_q && !aw_take && !O_BVALID;
      O_WREADY <= !w_held_q && !w_take && !O_BVALID;
      if (aw_take) begin
        aw_held_q <= 1'b1;
        awaddr_q <= I_AWADDR;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        wdata_q <= I_WDATA;
        wstrb_q <= I_WSTRB;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  // ****************************************
  // Write decode
  // ****************************************
  localparam int LANE_BITS = 2;
  logic full_lanes;
  logic wr_core_eoi, wr_tx_ctrl, wr_td, wr_dma_eoi, wr_tx_set, wr_tx_clr;
  logic wr_rx_ctrl, wr_rx_set, wr_rx_clr, wr_tally, wr_stat_clr;
  logic [NCH-1:0] wnib;
  assign full_lanes = &wstrb_q;
  assign wnib = wdata_q[NCH-1:0];
  assign wr_core_eoi = wr_fire && wstrb_q[0] && awaddr_q == OFS_CORE_EOI;
  assign wr_tx_ctrl = wr_fire && wstrb_q[0] && awaddr_q == OFS_TX_CTRL;
  assign wr_td = wr_fire && wstrb_q[0] && awaddr_q == OFS_TX_TEARDOWN;
  assign wr_dma_eoi = wr_fire && wstrb_q[0] && awaddr_q == OFS_DMA_EOI;
  assign wr_tx_set = wr_fire && wstrb_q[0] && awaddr_q == OFS_TX_IEN_SET;
  assign wr_tx_clr = wr_fire && wstrb_q[0] && awaddr_q == OFS_TX_IEN_CLR;
  assign wr_rx_ctrl = wr_fire && wstrb_q[0] && awaddr_q == OFS_RX_CTRL;
  assign wr_rx_set = wr_fire && wstrb_q[0] && awaddr_q == OFS_RX_IEN_SET;
  assign wr_rx_clr = wr_fire && wstrb_q[0] && awaddr_q == OFS_RX_IEN_CLR;
  assign wr_tally = wr_fire && full_lanes && awaddr_q == OFS_RX0_TALLY;
  assign wr_stat_clr = wr_fire && wstrb_q[0] && awaddr_q == OFS_STATUS_CLR;
  assign wr_hit = (awaddr_q <= OFS_STATUS_CLR) && (awaddr_q[LANE_BITS-1:0] == '0);

  // ****************************************
  // Control, teardown and acknowledge
  // ****************************************
  logic [VEC_W-1:0] core_vec_q;
  logic [VEC_W-1:0] dma_vec_q;
  logic td_ready;
  logic td_pend_q;
  logic td_accept;
  assign td_ready = !td_pend_q && !O_TEARDOWN_REQ && !td_busy_s;
  assign td_accept = wr_td && td_ready;
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_TX_DMA_RUN <= 1'b0;
      O_RX_DMA_RUN <= 1'b0;
      core_vec_q <= EOI_ACK_VEC;
      dma_vec_q <= EOI_ACK_VEC;
      O_CORE_EOI <= 1'b0;
      O_DMA_EOI <= 1'b0;
      O_TEARDOWN_REQ <= 1'b0;
      O_TEARDOWN_CHAN <= '0;
      td_pend_q <= 1'b0;
    end else begin
      if (wr_tx_ctrl) O_TX_DMA_RUN <= wdata_q[RUN_BIT];
      if (wr_rx_ctrl) O_RX_DMA_RUN <= wdata_q[RUN_BIT];
      if (wr_core_eoi) core_vec_q <= wdata_q[VEC_W-1:0];
      if (wr_dma_eoi) dma_vec_q <= wdata_q[VEC_W-1:0];
      O_CORE_EOI <= wr_core_eoi && wdata_q[VEC_W-1:0] == EOI_ACK_VEC;
      O_DMA_EOI <= wr_dma_eoi && wdata_q[VEC_W-1:0] == EOI_ACK_VEC;
      O_TEARDOWN_REQ <= td_accept;
      if (td_accept) O_TEARDOWN_CHAN <= wdata_q[CHAN_W-1:0];
      if (td_accept) td_pend_q <= 1'b1;
      else if (td_busy_s) td_pend_q <= 1'b0;
    end
  end

  // ****************************************
  // Completion flags and enables
  // ****************************************
  logic [NCH-1:0] tx_raw, tx_en, tx_msk;
  logic [NCH-1:0] rx_raw, rx_en, rx_msk;
  logic [NCH-1:0] tx_fclr, rx_fclr;
  assign tx_fclr = wr_stat_clr ? wnib : NCH_ZERO;
  assign rx_fclr = wr_stat_clr ? wdata_q[2*NCH-1:NCH] : NCH_ZERO;
  usb_dma_flag_bank u_tx_bank (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RESET_N),
    .i_event(tx_evt),
    .i_flag_clr(tx_fclr),
    .i_en_set(wr_tx_set ? wnib : NCH_ZERO),
    .i_en_clr(wr_tx_clr ? wnib : NCH_ZERO),
    .o_raw(tx_raw),
    .o_enable(tx_en),
    .o_masked(tx_msk)
  );
  usb_dma_flag_bank u_rx_bank (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RESET_N),
    .i_event(rx_evt),
    .i_flag_clr(rx_fclr),
    .i_en_set(wr_rx_set ? wnib : NCH_ZERO),
    .i_en_clr(wr_rx_clr ? wnib : NCH_ZERO),
    .o_raw(rx_raw),
    .o_enable(rx_en),
    .o_masked(rx_msk)
  );

  // ****************************************
  // Interrupt output
  // ****************************************
  logic irq_any;
  assign irq_any = |{tx_msk, rx_msk};
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_DMA_IRQ <= 1'b0;
    end else begin
      // level interrupt, dropped for a cycle on acknowledge
      O_DMA_IRQ <= irq_any && !(wr_dma_eoi && wdata_q[VEC_W-1:0] == EOI_ACK_VEC);
    end
  end

  // ****************************************
  // Receive channel 0 buffer tally
  // ****************************************
  logic [TALLY_W-1:0] tally_q, tally_d, tally_add, tally_sub;
  assign tally_add = wr_tally ? wdata_q[TALLY_W-1:0] : TALLY_ZERO;
  assign tally_sub = (rx0_take_evt && tally_q != TALLY_ZERO) ? TALLY_ONE : TALLY_ZERO;
  assign tally_d = tally_q + tally_add - tally_sub;
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      tally_q <= TALLY_ZERO;
    end else begin
      tally_q <= tally_d;
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  logic [31:0] rd_mux;
  logic rd_hit;
  logic ar_take;
  assign ar_take = I_ARVALID && O_ARREADY;
  always_comb begin
    rd_mux = WORD_ZERO;
    rd_hit = 1'b1;
    case (I_ARADDR)
      OFS_CORE_EOI: rd_mux[VEC_W-1:0] = core_vec_q;
      OFS_TX_CTRL: rd_mux[RUN_BIT] = O_TX_DMA_RUN;
      OFS_TX_TEARDOWN: begin
        rd_mux[READY_BIT] = td_ready;
        rd_mux[CHAN_W-1:0] = O_TEARDOWN_CHAN;
      end
      OFS_DMA_EOI: rd_mux[VEC_W-1:0] = dma_vec_q;
      OFS_TX_MASKED: rd_mux[NCH-1:0] = tx_msk;
      OFS_TX_RAW: rd_mux[NCH-1:0] = tx_raw;
      OFS_TX_IEN_SET: rd_mux[NCH-1:0] = tx_en;
      OFS_TX_IEN_CLR: rd_mux[NCH-1:0] = tx_en;
      OFS_RX_CTRL: rd_mux[RUN_BIT] = O_RX_DMA_RUN;
      OFS_RX_MASKED: rd_mux[NCH-1:0] = rx_msk;
      OFS_RX_RAW: rd_mux[NCH-1:0] = rx_raw;
      OFS_RX_IEN_SET: rd_mux[NCH-1:0] = rx_en;
      OFS_RX_IEN_CLR: rd_mux[NCH-1:0] = rx_en;
      OFS_RX0_TALLY: rd_mux[TALLY_W-1:0] = tally_q;
      OFS_STATUS_CLR: rd_mux = WORD_ZERO;
      default: rd_hit = 1'b0;
    endcase
  end
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b0;
      O_RDATA <= WORD_ZERO;
      O_RRESP <= RESP_OKAY;
    end else begin
      O_ARREADY <= !O_RVALID && !ar_take;
      if (ar_take) begin
        O_RVALID <= 1'b1;
        O_RDATA <= rd_mux;
        O_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (O_RVALID && I_RREADY) begin
        O_RVALID <= 1'b0;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESET_N);
  irq_follows_mask_a: assert property (
    irq_any && !wr_dma_eoi |=> O_DMA_IRQ) else $error("irq not raised");
  irq_quiet_a: assert property (
    !irq_any |=> !O_DMA_IRQ) else $error("irq without masked bit");
  tx_run_write_a: assert property (
    wr_tx_ctrl |=> O_TX_DMA_RUN == $past(wdata_q[RUN_BIT])) else $error("tx run wrong");
  rx_run_write_a: assert property (
    wr_rx_ctrl |=> O_RX_DMA_RUN == $past(wdata_q[RUN_BIT])) else $error("rx run wrong");
  tx_event_sets_a: assert property (
    |tx_evt |=> (tx_raw & $past(tx_evt)) == $past(tx_evt)) else $error("tx flag lost");
  rx_event_sets_a: assert property (
    |rx_evt |=> (rx_raw & $past(rx_evt)) == $past(rx_evt)) else $error("rx flag lost");
  tx_masked_and_a: assert property (
    tx_msk == (tx_raw & tx_en)) else $error("tx masked wrong");
  rx_masked_and_a: assert property (
    rx_msk == (rx_raw & rx_en)) else $error("rx masked wrong");
  tx_en_clear_a: assert property (
    wr_tx_clr |=> (tx_en & $past(wnib)) == NCH_ZERO) else $error("tx enable not cleared");
  rx_en_set_a: assert property (
    wr_rx_set |=> (rx_en & $past(wnib)) == $past(wnib)) else $error("rx enable not set");
  rx_en_clear_a: assert property (
    wr_rx_clr |=> (rx_en & $past(wnib)) == NCH_ZERO) else $error("rx enable stuck");
  tally_accum_a: assert property (
    wr_tally && !rx0_take_evt |=> tally_q == $past(tally_q) + $past(wdata_q[TALLY_W-1:0]))
    else $error("tally did not add");
  tally_dec_a: assert property (
    rx0_take_evt && !wr_tally && tally_q != TALLY_ZERO |=> tally_q == $past(tally_q) - 1'b1)
    else $error("tally did not drop");
  teardown_gate_a: assert property (
    wr_td && !td_ready |=> !O_TEARDOWN_REQ) else $error("teardown taken while busy");
  teardown_chan_a: assert property (
    td_accept |=> O_TEARDOWN_REQ && O_TEARDOWN_CHAN == $past(wdata_q[CHAN_W-1:0]))
    else $error("teardown channel wrong");
  eoi_ack_a: assert property (
    wr_dma_eoi && wdata_q[VEC_W-1:0] == EOI_ACK_VEC |=> O_DMA_EOI) else $error("no dma ack");
  core_ack_a: assert property (
    O_CORE_EOI |-> $past(wr_core_eoi)) else $error("spurious core ack");
  irq_raise_c: cover property (wr_tx_set ##2 O_DMA_IRQ);
  teardown_c: cover property (td_accept ##1 O_TEARDOWN_REQ);
  tally_c: cover property (wr_tally ##[1:20] rx0_take_evt);
  eoi_c: cover property (O_DMA_IRQ ##1 O_DMA_EOI);
endmodule

// ---- tb/usb_dma_control_irq_regs_test.sv ----
// Self-checking bench for the DMA control and interrupt register block
module usb_dma_control_irq_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import usb_dma_regs_pkg::*;
  logic clk, rst_n, aw_valid, w_valid, b_ready, ar_valid, r_ready;
  logic [7:0] aw_addr, ar_addr;
  logic [31:0] w_data, rd;
  logic [3:0] tx_done, rx_done, w_strb;
  logic buf_taken, td_busy;
  logic awready, wready, bvalid, arready, rvalid, tx_run, rx_run, td_req, core_eoi, dma_eoi, irq;
  logic [1:0] bresp, rresp, rs, td_chan;
  logic [31:0] rdata;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int core_n = 0;
  int dma_n = 0;
  int td_n = 0;

  usb_dma_control_irq_regs uut (
    .I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_AWADDR(aw_addr), .I_AWVALID(aw_valid),
    .O_AWREADY(awready), .I_WDATA(w_data), .I_WSTRB(w_strb), .I_WVALID(w_valid),
    .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(b_ready),
    .I_ARADDR(ar_addr), .I_ARVALID(ar_valid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(r_ready), .I_TX_DONE(tx_done),
    .I_RX_DONE(rx_done), .I_RX0_BUF_TAKEN(buf_taken), .I_TEARDOWN_BUSY(td_busy),
    .O_TX_DMA_RUN(tx_run), .O_RX_DMA_RUN(rx_run), .O_TEARDOWN_REQ(td_req),
    .O_TEARDOWN_CHAN(td_chan), .O_CORE_EOI(core_eoi), .O_DMA_EOI(dma_eoi), .O_DMA_IRQ(irq)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ****************************************
  // Pulse counters and timeout
  // ****************************************
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (core_eoi === 1'b1) core_n <= core_n + 1;
    if (dma_eoi === 1'b1) dma_n <= dma_n + 1;
    if (td_req === 1'b1) td_n <= td_n + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      summarize();
    end
  end

  task automatic summarize();
    if (err_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      err_count = err_count + 1;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    bit done;
    n = 0;
    done = 0;
    r = 2'b11;
    @(posedge clk);
    aw_addr <= a;
    aw_valid <= 1'b1;
    w_data <= d;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      n++;
      if (aw_valid && awready) aw_valid <= 1'b0;
      if (w_valid && wready) w_valid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        b_ready <= 1'b0;
        done = 1;
      end else if (n > 100) begin
        err_count = err_count + 1;
        summarize();
      end
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    bit done;
    n = 0;
    done = 0;
    @(posedge clk);
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      n++;
      if (ar_valid && arready) ar_valid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        r_ready <= 1'b0;
        done = 1;
      end else if (n > 100) begin
        err_count = err_count + 1;
        summarize();
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(d, exp);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    {aw_valid, w_valid, b_ready, ar_valid, r_ready, buf_taken, td_busy} = 7'h00;
    aw_addr = 8'h00;
    ar_addr = 8'h00;
    w_data = 32'h0000_0000;
    w_strb = 4'hF;
    tx_done = 4'h0;
    rx_done = 4'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    tick(2);
    rd_chk(OFS_TX_RAW, WORD_ZERO);
    rd_chk(OFS_RX0_TALLY, WORD_ZERO);
    wr(OFS_TX_CTRL, 32'h0000_0001);
    wr(OFS_RX_CTRL, 32'h0000_0001);
    check({31'h0, tx_run}, 32'h0000_0001);
    check({31'h0, rx_run}, 32'h0000_0001);
    wr(OFS_TX_CTRL, 32'h0000_0000);
    check({31'h0, tx_run}, 32'h0000_0000);
    rd_chk(OFS_RX_CTRL, 32'h0000_0001);
    wr(OFS_CORE_EOI, 32'h0000_0055);
    rd_chk(OFS_CORE_EOI, 32'h0000_0055);
    wr(OFS_CORE_EOI, 32'h0000_0000);
    tick(2);
    check(32'(core_n), 32'h0000_0001);
    tx_done <= 4'h6;
    tick(6);
    tx_done <= 4'h0;
    rd_chk(OFS_TX_RAW, 32'h0000_0006);
    wr(OFS_TX_IEN_SET, 32'h0000_000F);
    wr(OFS_TX_IEN_CLR, 32'h0000_0005);
    rd_chk(OFS_TX_IEN_SET, 32'h0000_000A);
    rd_chk(OFS_TX_MASKED, 32'h0000_0002);
    tick(2);
    check({31'h0, irq}, 32'h0000_0001);
    wr(OFS_TX_IEN_CLR, 32'h0000_000F);
    tick(2);
    check({31'h0, irq}, 32'h0000_0000);
    rd_chk(OFS_TX_MASKED, 32'h0000_0000);
    rx_done <= 4'h9;
    tick(6);
    rx_done <= 4'h0;
    rd_chk(OFS_RX_RAW, 32'h0000_0009);
    wr(OFS_RX_IEN_SET, 32'h0000_000D);
    wr(OFS_RX_IEN_CLR, 32'h0000_0004);
    rd_chk(OFS_RX_IEN_SET, 32'h0000_0009);
    wr(OFS_RX_IEN_SET, 32'h0000_0002);
    rd_chk(OFS_RX_IEN_CLR, 32'h0000_000B);
    rd_chk(OFS_RX_MASKED, 32'h0000_0009);
    wr(OFS_DMA_EOI, 32'h0000_0000);
    tick(4);
    check(32'(dma_n), 32'h0000_0001);
    check({31'h0, irq}, 32'h0000_0001);
    wr(OFS_STATUS_CLR, 32'h0000_0090);
    tick(2);
    check({31'h0, irq}, 32'h0000_0000);
    rd_chk(OFS_RX_MASKED, 32'h0000_0000);
    rd_chk(OFS_TX_RAW, 32'h0000_0006);
    wr(OFS_RX0_TALLY, 32'h0000_0005);
    wr(OFS_RX0_TALLY, 32'h0000_0003);
    rd_chk(OFS_RX0_TALLY, 32'h0000_0008);
    buf_taken <= 1'b1;
    tick(2);
    buf_taken <= 1'b0;
    tick(6);
    rd_chk(OFS_RX0_TALLY, 32'h0000_0007);
    wr(OFS_RX0_TALLY, 32'h0000_FFFF);
    rd_chk(OFS_RX0_TALLY, 32'h0000_0006);
    w_strb <= 4'h3;
    wr(OFS_RX0_TALLY, 32'h0000_0004);
    wr(OFS_TX_CTRL, 32'h0000_0001);
    w_strb <= 4'h0;
    wr(OFS_TX_CTRL, 32'h0000_0000);
    w_strb <= 4'hF;
    rd_chk(OFS_RX0_TALLY, 32'h0000_0006);
    check({31'h0, tx_run}, 32'h0000_0001);
    axi_read(OFS_TX_TEARDOWN, rd, rs);
    check({31'h0, rd[READY_BIT]}, 32'h0000_0001);
    wr(OFS_TX_TEARDOWN, 32'h0000_0002);
    tick(2);
    check(32'(td_n), 32'h0000_0001);
    check({30'h0, td_chan}, 32'h0000_0002);
    axi_read(OFS_TX_TEARDOWN, rd, rs);
    check({31'h0, rd[READY_BIT]}, 32'h0000_0000);
    wr(OFS_TX_TEARDOWN, 32'h0000_0001);
    tick(2);
    check(32'(td_n), 32'h0000_0001);
    check({30'h0, td_chan}, 32'h0000_0002);
    td_busy <= 1'b1;
    tick(6);
    td_busy <= 1'b0;
    tick(6);
    axi_read(OFS_TX_TEARDOWN, rd, rs);
    check({31'h0, rd[READY_BIT]}, 32'h0000_0001);
    // Unmapped address
    axi_write(8'h3C, 32'h0000_0001, rs);
    check({30'h0, rs}, {30'h0, RESP_SLVERR});
    axi_read(8'h3C, rd, rs);
    check(rd, WORD_ZERO);
    check({30'h0, rs}, {30'h0, RESP_SLVERR});
    summarize();
  end
endmodule
